// >>> lpdc_cfg.svh
`ifndef LPDC_CFG_SVH
`define LPDC_CFG_SVH

// command word (Q) field positions
`define LPDC_Q_CODE      0
`define LPDC_Q_MBZ       6
`define LPDC_Q_EQ_LSB    7
`define LPDC_Q_EQ_MSB    10
`define LPDC_Q_W_LSB     11
`define LPDC_Q_W_MSB     15

// director function bits (A)
`define LPDC_FN_CLRPRN   0
`define LPDC_FN_CLRINT   1
`define LPDC_FN_INTDATA  2
`define LPDC_FN_INTEOP   3
`define LPDC_FN_INTALRM  4
`define LPDC_FN_PRINT    5
`define LPDC_FN_ADT      6

// director status bits
`define LPDC_ST_READY    0
`define LPDC_ST_BUSY     1
`define LPDC_ST_INT      2
`define LPDC_ST_DATA     3
`define LPDC_ST_EOP      4
`define LPDC_ST_ALARM    5
`define LPDC_ST_ERROR    6
`define LPDC_ST_PROT     7

// widths and reset values
`define LPDC_WORD_W      16
`define LPDC_DATA_W      8
`define LPDC_WORD_RST    16'h0000
`define LPDC_DATA_RST    8'h00

// clear controller time
`define LPDC_CLK_NS      10
`define LPDC_CLR_NS      5000
`define LPDC_CLR_CYC     ((`LPDC_CLR_NS + `LPDC_CLK_NS - 1) / `LPDC_CLK_NS)
`define LPDC_CLR_W       10

`endif

// >>> lpdc_pkg.sv
package lpdc_pkg;

  // one channel request: strobes, protect bit, Q and A words
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        prot;
    logic [15:0] q;
    logic [15:0] a;
  } lpdc_chan_type;

  // printer-side condition lines
  typedef struct packed {
    logic supplyOk;
    logic fuseOk;
    logic paperOk;
    logic gateOk;
    logic motionFault;
    logic imageVar;
    logic imageOk;
    logic loadLamp;
    logic motionBusy;
    logic canAccept;
    logic lineDone;
    logic opDone;
    logic malfunction;
    logic parityErr;
    logic syncErr;
    logic cmpErr;
  } lpdc_prn_type;

  typedef enum logic [1:0] {IDLE, PRINT, CLEARING} lpdc_state_type;

endpackage

// >>> lpdc_pair_buf.sv
`timescale 1ns/10ps
`include "lpdc_cfg.svh"

module lpdc_pair_buf (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    inValid,
  output logic                         inReady,
  input  wire logic [`LPDC_DATA_W-1:0] inData,
  output logic                         outValid,
  input  wire logic                    outReady,
  output logic      [`LPDC_DATA_W-1:0] outData
);
  logic [1:0]              cnt_r;
  logic [`LPDC_DATA_W-1:0] head_r;
  logic [`LPDC_DATA_W-1:0] tail_r;
  logic                    push;
  logic                    pop;

  // honest full and empty from the fill count
  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = head_r;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 2'h0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // head slot drives the output data directly
  always_ff @(posedge clk) begin
    if (reset) begin
      head_r <= `LPDC_DATA_RST;
    end else if (pop) begin
      if (cnt_r == 2'h2) begin
        head_r <= tail_r;
      end else if (push) begin
        head_r <= inData;
      end
    end else if (push && cnt_r == 2'h0) begin
      head_r <= inData;
    end
  end

  // second slot catches a word while the head waits
  always_ff @(posedge clk) begin
    if (reset) begin
      tail_r <= `LPDC_DATA_RST;
    end else if (push && !pop && cnt_r == 2'h1) begin
      tail_r <= inData;
    end
  end
endmodule

// >>> lpdc_director.sv
`timescale 1ns/10ps
`include "lpdc_cfg.svh"

//Contract
// - clear-interrupts wipes requests; new enables still win
// - data interrupt enable, cleared by clears
// - data response withdrawn during transfer or print
// - no end-of-operation response for earlier completions
// - end-of-operation enable cleared by clears, re-armable
// - alarm response immediate if alarm already present
// - print cycle; data status zero throughout
// - auto transfer mode follows function bit six
// - stacked functions: clear first, then others
// - status read always answered with status word
// - ready needs supply, fuse, paper, gate, no motion fault and image good; malfunction not included
// - busy during print or paper motion
// - interrupt status bit set on any response
// - data status: printer can accept data
// - end-of-operation status set on completion, clearable
// - alarm clears only once cause has gone
// - basic variant error: parity, ready kept
// - image variant error: parity, sync, compare
// - protect status shows jumper fitted
// - clear printer wipes control, needs ready idle
// - command bit decodes operation; illegal read rejected
// - protect violation rejected except status read
// - data accepted only ready, idle, data set
module lpdc_director (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  lpdc_pkg::lpdc_chan_type            chanReq,
  input  wire logic [3:0]                    equipCode,
  input  wire logic                          protectJumper,
  input  lpdc_pkg::lpdc_prn_type             prnIn,
  output logic                               chanReply,
  output logic                               chanReject,
  output logic      [`LPDC_WORD_W-1:0]       chanRdData,
  output logic      [`LPDC_DATA_W-1:0]       prnData,
  output logic                               prnValid,
  input  wire logic                          prnReady,
  output logic                               printStart,
  output logic                               irqCommon,
  output logic                               irqAdt
);
  import lpdc_pkg::*;

  lpdc_state_type          state_r;
  logic [`LPDC_CLR_W-1:0]  clrCnt_r;
  logic [2:0]              en_r;
  logic                    eopRsp_r;
  logic                    eopStat_r;
  logic                    errStat_r;
  logic                    alarmStat_r;
  logic                    adt_r;
  logic                    xferHold_r;
  logic                    chanReply_r;
  logic                    chanReject_r;
  logic                    printStart_r;
  logic [`LPDC_WORD_W-1:0] rdData_r;
  logic [`LPDC_WORD_W-1:0] statVec;
  logic                    hitWr;
  logic                    hitRd;
  logic                    codeBit;
  logic                    protViol;
  logic                    isStat;
  logic                    isFn;
  logic                    isData;
  logic                    accept;
  logic                    doClrPrn;
  logic                    clrInt;
  logic                    doPrint;
  logic                    clrEv;
  logic                    opEnd;
  logic                    ready;
  logic                    busy;
  logic                    dataStat;
  logic                    bufInReady;
  logic                    errCause;
  logic                    alarmCause;
  logic                    dataRsp;
  logic                    alarmRsp;
  logic                    anyRsp;

  // equipment match with the must-be-zero fields clear
  function automatic logic chanHit(input logic [15:0] q, input logic [3:0] code);
    chanHit = (q[`LPDC_Q_EQ_MSB:`LPDC_Q_EQ_LSB] == code)
            && (q[`LPDC_Q_W_MSB:`LPDC_Q_W_LSB] == 5'h00)
            && !q[`LPDC_Q_MBZ];
  endfunction

  // request decode
  assign hitWr    = chanReq.wr & chanHit(chanReq.q, equipCode);
  assign hitRd    = chanReq.rd & chanHit(chanReq.q, equipCode);
  assign codeBit  = chanReq.q[`LPDC_Q_CODE];
  assign protViol = protectJumper & !chanReq.prot;
  assign isStat   = hitRd & codeBit;
  assign isFn     = hitWr & codeBit & !protViol;
  assign isData   = hitWr & !codeBit & !protViol & dataStat;
  assign accept   = isStat | isFn | isData;

  // function strobes; a clear acts first, stacked bits after
  assign doClrPrn = isFn & chanReq.a[`LPDC_FN_CLRPRN] & ready & !busy;
  assign clrInt   = isFn & (chanReq.a[`LPDC_FN_CLRINT] | doClrPrn);
  assign doPrint  = isFn & chanReq.a[`LPDC_FN_PRINT] & (state_r == IDLE);
  assign clrEv    = doClrPrn | isData | doPrint;

  // printer condition summary
  assign ready = prnIn.supplyOk & prnIn.fuseOk & prnIn.paperOk & prnIn.gateOk
               & !prnIn.motionFault
               & (!prnIn.imageVar | prnIn.imageOk | prnIn.loadLamp);
  assign busy  = (state_r == PRINT) | prnIn.motionBusy;
  assign opEnd = prnIn.opDone | ((state_r == PRINT) & prnIn.lineDone);

  // data status drops while printing, clearing or draining a transfer
  assign dataStat = ready & !busy & (state_r == IDLE) & prnIn.canAccept
                  & bufInReady & !xferHold_r;

  // error and alarm causes; an error wiped by a clear event no longer holds the alarm
  assign errCause   = prnIn.parityErr
                    | (prnIn.imageVar & (prnIn.syncErr | prnIn.cmpErr));
  assign alarmCause = errCause | (errStat_r & !clrEv) | prnIn.malfunction;

  // interrupt responses
  assign dataRsp  = en_r[0] & dataStat;
  assign alarmRsp = en_r[2] & alarmStat_r;
  assign anyRsp   = dataRsp | eopRsp_r | alarmRsp;

  // interrupt lines to the selection matrix
  assign irqCommon = anyRsp;
  assign irqAdt    = adt_r & dataRsp & !eopRsp_r & !alarmRsp;

  // status word as the host sees it
  always_comb begin
    statVec                 = `LPDC_WORD_RST;
    statVec[`LPDC_ST_READY] = ready;
    statVec[`LPDC_ST_BUSY]  = busy;
    statVec[`LPDC_ST_INT]   = anyRsp;
    statVec[`LPDC_ST_DATA]  = dataStat;
    statVec[`LPDC_ST_EOP]   = eopStat_r;
    statVec[`LPDC_ST_ALARM] = alarmStat_r;
    statVec[`LPDC_ST_ERROR] = errStat_r;
    statVec[`LPDC_ST_PROT]  = protectJumper;
  end

  // print and clear sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= IDLE;
    end else begin
      case (state_r)
        IDLE: begin
          if (doPrint) begin
            state_r <= PRINT;
          end else if (doClrPrn) begin
            state_r <= CLEARING;
          end
        end
        PRINT: begin
          if (prnIn.lineDone) begin
            state_r <= IDLE;
          end
        end
        CLEARING: begin
          if (clrCnt_r == `LPDC_CLR_W'(`LPDC_CLR_CYC - 1)) begin
            state_r <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // clear duration counter
  always_ff @(posedge clk) begin
    if (reset || state_r != CLEARING) begin
      clrCnt_r <= '0;
    end else begin
      clrCnt_r <= clrCnt_r + `LPDC_CLR_W'(1);
    end
  end

  // one enable per source: data, end of operation, alarm
  genvar g;
  for (g = 0; g < 3; g++) begin : gEnable
    always_ff @(posedge clk) begin
      if (reset) begin
        en_r[g] <= 1'b0;
      end else if (isFn && chanReq.a[`LPDC_FN_INTDATA + g]) begin
        en_r[g] <= 1'b1;
      end else if (clrInt) begin
        en_r[g] <= 1'b0;
      end
    end
  end

  // end-of-operation response only for completions seen while enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      eopRsp_r <= 1'b0;
    end else if (en_r[1] && opEnd) begin
      eopRsp_r <= 1'b1;
    end else if (clrInt) begin
      eopRsp_r <= 1'b0;
    end
  end

  // end-of-operation status
  always_ff @(posedge clk) begin
    if (reset) begin
      eopStat_r <= 1'b0;
    end else if (opEnd) begin
      eopStat_r <= 1'b1;
    end else if (clrEv) begin
      eopStat_r <= 1'b0;
    end
  end

  // error status; a new error beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      errStat_r <= 1'b0;
    end else if (errCause) begin
      errStat_r <= 1'b1;
    end else if (clrEv) begin
      errStat_r <= 1'b0;
    end
  end

  // alarm holds while its cause stays
  always_ff @(posedge clk) begin
    if (reset) begin
      alarmStat_r <= 1'b0;
    end else begin
      alarmStat_r <= alarmCause | (alarmStat_r & !clrEv);
    end
  end

  // auto transfer mode follows every director function
  always_ff @(posedge clk) begin
    if (reset) begin
      adt_r <= 1'b0;
    end else if (isFn) begin
      adt_r <= chanReq.a[`LPDC_FN_ADT];
    end
  end

  // hold off data status until the buffer has drained
  always_ff @(posedge clk) begin
    if (reset) begin
      xferHold_r <= 1'b0;
    end else if (isData) begin
      xferHold_r <= 1'b1;
    end else if (!prnValid) begin
      xferHold_r <= 1'b0;
    end
  end

  // channel answers one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      chanReply_r  <= 1'b0;
      chanReject_r <= 1'b0;
    end else begin
      chanReply_r  <= accept;
      chanReject_r <= (hitWr | hitRd) & !accept;
    end
  end

  // status word captured on a status read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_r <= `LPDC_WORD_RST;
    end else if (isStat) begin
      rdData_r <= statVec;
    end
  end

  // print strobe to the printer
  always_ff @(posedge clk) begin
    if (reset) begin
      printStart_r <= 1'b0;
    end else begin
      printStart_r <= doPrint;
    end
  end

  assign chanReply  = chanReply_r;
  assign chanReject = chanReject_r;
  assign chanRdData = rdData_r;
  assign printStart = printStart_r;

  // two-entry buffer toward the printer absorbs its stalls
  lpdc_pair_buf uBuf (
    .clk      (clk),
    .reset    (reset),
    .inValid  (isData),
    .inReady  (bufInReady),
    .inData   (chanReq.a[`LPDC_DATA_W-1:0]),
    .outValid (prnValid),
    .outReady (prnReady),
    .outData  (prnData)
  );

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seqEopArm;
    !en_r[1] && !eopRsp_r ##1 isFn && chanReq.a[`LPDC_FN_INTEOP] && !opEnd;
  endsequence

  sequence seqPrintGo;
    doPrint && !prnIn.lineDone ##1 state_r == PRINT;
  endsequence

  AST_CLR_INT: assert property (
    clrInt && !chanReq.a[`LPDC_FN_INTDATA] |=> !en_r[0] && !dataRsp)
    else $error("data enable survived a clear");

  AST_REARM: assert property (
    clrInt && chanReq.a[`LPDC_FN_INTDATA] |=> en_r[0])
    else $error("data enable not re-armed with clear");

  AST_EOP_STALE: assert property (
    seqEopArm |=> !eopRsp_r)
    else $error("end-of-operation response for old completion");

  AST_ALARM_NOW: assert property (
    isFn && chanReq.a[`LPDC_FN_INTALRM] && alarmCause |=> irqCommon && statVec[`LPDC_ST_INT])
    else $error("alarm response not immediate");

  AST_PRINT_DATA: assert property (
    seqPrintGo |-> !statVec[`LPDC_ST_DATA] && statVec[`LPDC_ST_BUSY])
    else $error("data status set during print");

  AST_ADT: assert property (
    isFn |=> adt_r == $past(chanReq.a[`LPDC_FN_ADT]))
    else $error("auto transfer mode not taken from function");

  AST_STAT_READ: assert property (
    isStat |=> chanReply && !chanReject && chanRdData == $past(statVec))
    else $error("status read not answered with status word");

  AST_ALARM_HOLD: assert property (
    alarmStat_r && alarmCause |=> alarmStat_r)
    else $error("alarm cleared while cause present");

  AST_ILLEGAL: assert property (
    hitRd && !codeBit |=> chanReject && !chanReply)
    else $error("illegal read not rejected");

  AST_PROTECT: assert property (
    hitWr && protViol |=> chanReject)
    else $error("protect violation not rejected");

  AST_DATA_GATE: assert property (
    hitWr && !codeBit && !dataStat |=> chanReject && !$rose(prnValid))
    else $error("data taken while not ready for data");

  AST_UPPER_ZERO: assert property (
    chanReply |-> chanRdData[15:8] == 8'h00)
    else $error("upper status bits not zero");
endmodule

// >>> lpdc_prn_model.sv
`timescale 1ns/10ps

module lpdc_prn_model #(
  parameter int LINE_CYC = 40,
  parameter int STALL    = 12
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [8:0] ctl,
  input  wire logic [2:0] errPulse,
  input  wire logic       prnValid,
  input  wire logic       printStart,
  output lpdc_pkg::lpdc_prn_type prnIn,
  output logic            prnReady
);
  import lpdc_pkg::*;

  int   lineCnt;
  int   stallCnt;
  logic printing;

  // condition lines follow the bench knobs; canAccept drops while a line prints
  always_comb begin
    prnIn             = '0;
    prnIn.supplyOk    = !ctl[0];
    prnIn.fuseOk      = !ctl[1];
    prnIn.paperOk     = !ctl[2];
    prnIn.gateOk      = !ctl[3];
    prnIn.motionFault = ctl[4];
    prnIn.malfunction = ctl[5];
    prnIn.imageOk     = !ctl[6];
    prnIn.imageVar    = ctl[7];
    prnIn.motionBusy  = ctl[8];
    prnIn.canAccept   = !printing;
    prnIn.lineDone    = printing && (lineCnt == LINE_CYC);
    prnIn.parityErr   = errPulse[0];
    prnIn.syncErr     = errPulse[1];
    prnIn.cmpErr      = errPulse[2];
  end

  // a print cycle lasts a fixed number of cycles, then one line-done pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      printing <= 1'b0;
      lineCnt  <= 0;
    end else if (printStart) begin
      printing <= 1'b1;
      lineCnt  <= 0;
    end else if (printing) begin
      lineCnt <= lineCnt + 1;
      if (lineCnt == LINE_CYC) begin
        printing <= 1'b0;
      end
    end
  end

  // the printer stalls each byte for a while before taking it
  always_ff @(posedge clk) begin
    if (reset || (prnValid && prnReady)) begin
      stallCnt <= 0;
      prnReady <= 1'b0;
    end else if (prnValid) begin
      stallCnt <= stallCnt + 1;
      prnReady <= (stallCnt >= STALL - 1);
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps

module testbench;
  import lpdc_pkg::*;

  localparam int LINE_CYC = 40;
  localparam int CLR_WAIT = 520;

  logic          clk, reset, protectJumper, chanReply, chanReject;
  logic          prnValid, prnReady, printStart, irqCommon, irqAdt;
  logic [3:0]    equipCode;
  logic [15:0]   chanRdData;
  logic [7:0]    prnData;
  logic [8:0]    ctl;
  logic [2:0]    errPulse;
  lpdc_chan_type chanReq;
  lpdc_prn_type  prnIn;
  logic [17:0]   expQ[$];
  logic [7:0]    byteQ[$];
  logic [15:0]   rng;
  int            n_fail, compares, starts, k;

  lpdc_director DUT (.clk(clk), .reset(reset), .chanReq(chanReq), .equipCode(equipCode),
    .protectJumper(protectJumper), .prnIn(prnIn), .chanReply(chanReply),
    .chanReject(chanReject), .chanRdData(chanRdData), .prnData(prnData),
    .prnValid(prnValid), .prnReady(prnReady), .printStart(printStart),
    .irqCommon(irqCommon), .irqAdt(irqAdt));

  lpdc_prn_model #(.LINE_CYC(LINE_CYC)) model_i (.clk(clk), .reset(reset), .ctl(ctl),
    .errPulse(errPulse), .prnValid(prnValid), .printStart(printStart), .prnIn(prnIn),
    .prnReady(prnReady));

  // free-running clock
  always #5 clk = ~clk;

  function automatic logic [15:0] nextRand(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction

  task automatic miss(input logic [15:0] e, input logic [15:0] g);
    n_fail++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask

  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) miss(e, g);
  endtask

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) miss({8'h00, e}, {8'h00, g});
  endtask

  task automatic cmp_flag(input logic e, input logic g);
    compares++;
    if (g !== e) miss({15'h0000, e}, {15'h0000, g});
  endtask

  task automatic wrap_up;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // one channel request, held for one cycle; the answer is noted for the monitor
  task automatic req(input logic wr, rd, pr, input logic [15:0] q, a,
                     input logic rej, isRd, input logic [15:0] w);
    int i;
    @(negedge clk);
    chanReq = '{wr, rd, pr, q, a};
    expQ.push_back({isRd, rej, w});
    @(negedge clk);
    chanReq = '0;
    for (i = 0; i < 8 && expQ.size() > 0; i++) @(negedge clk);
    if (expQ.size() > 0) begin
      miss(16'h0001, 16'h0000);
      wrap_up();
    end
  endtask

  task automatic fn(input logic [15:0] a);
    req(1'b1, 1'b0, 1'b1, 16'h0201, a, 1'b0, 1'b0, 16'h0000);
  endtask

  task automatic st(input logic [15:0] w);
    req(1'b0, 1'b1, 1'b0, 16'h0201, 16'h0000, 1'b0, 1'b1, w);
  endtask

  // monitor: answers, bytes to the printer and print starts
  always @(negedge clk) begin
    logic [17:0] e;
    if (chanReply === 1'b1 || chanReject === 1'b1) begin
      if (expQ.size() == 0) begin
        miss(16'h0000, 16'h0001);
      end else begin
        e = expQ.pop_front();
        cmp_flag(e[16], chanReject);
        if (e[17]) cmp_word(e[15:0], chanRdData);
      end
    end
    if (prnValid === 1'b1 && prnReady === 1'b1) begin
      if (byteQ.size() == 0) miss(16'h0000, {8'h00, prnData});
      else cmp_byte(byteQ.pop_front(), prnData);
    end
    if (printStart === 1'b1) starts++;
  end

  // hang guard
  initial begin
    #800000;
    miss(16'h0001, 16'h0000);
    wrap_up();
  end

  // main sequence
  initial begin
    clk = 1'b0; reset = 1'b1; chanReq = '0; equipCode = 4'h4; protectJumper = 1'b0;
    ctl = 9'h000; errPulse = 3'h0; n_fail = 0; compares = 0; starts = 0; rng = 16'h6ccc;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    idle(2);
    st(16'h0009);
    req(1'b0, 1'b1, 1'b0, 16'h0200, 16'h0000, 1'b1, 1'b0, 16'h0000);
    done("decode");
    fn(16'h0004);
    idle(1);
    cmp_flag(1'b1, irqCommon);
    st(16'h000d);
    for (k = 0; k < 4; k++) begin
      rng = nextRand(rng);
      byteQ.push_back(rng[7:0]);
      req(1'b1, 1'b0, 1'b1, 16'h0200, {8'h00, rng[7:0]}, 1'b0, 1'b0, 16'h0000);
      if (k == 0) begin
        req(1'b1, 1'b0, 1'b1, 16'h0200, 16'h00a5, 1'b1, 1'b0, 16'h0000);
        cmp_flag(1'b0, irqCommon);
        st(16'h0001);
      end
      idle(30);
      st(16'h000d);
    end
    cmp_word(16'h0000, 16'(byteQ.size()));
    done("data");
    fn(16'h000a);
    st(16'h0009);
    fn(16'h0028);
    st(16'h0003);
    idle(LINE_CYC + 20);
    st(16'h001d);
    cmp_word(16'h0001, 16'(starts));
    fn(16'h0002);
    st(16'h0019);
    fn(16'h0008);
    st(16'h0019);
    done("print");
    fn(16'h0044);
    idle(1);
    cmp_flag(1'b1, irqAdt);
    fn(16'h0004);
    idle(1);
    cmp_flag(1'b0, irqAdt);
    fn(16'h0001);
    idle(CLR_WAIT);
    st(16'h0009);
    done("adt");
    ctl = 9'h020;
    idle(2);
    st(16'h0029);
    fn(16'h0010);
    idle(1);
    cmp_flag(1'b1, irqCommon);
    fn(16'h0001);
    idle(CLR_WAIT);
    st(16'h0029);
    ctl = 9'h000;
    fn(16'h0001);
    idle(CLR_WAIT);
    st(16'h0009);
    done("alarm");
    for (k = 0; k < 3; k++) begin
      ctl = (k == 0) ? 9'h000 : 9'h080;
      idle(2);
      errPulse[k] = 1'b1;
      idle(1);
      errPulse = 3'h0;
      idle(2);
      st(16'h0069);
      fn(16'h0001);
      idle(CLR_WAIT);
      st(16'h0009);
    end
    done("error");
    for (k = 0; k < 7; k++) begin
      if (k != 5) begin
        ctl = (9'h001 << k) | ((k == 6) ? 9'h080 : 9'h000);
        idle(2);
        st(16'h0000);
      end
    end
    ctl = 9'h100;
    idle(2);
    st(16'h0003);
    ctl = 9'h000;
    done("ready");
    protectJumper = 1'b1;
    idle(2);
    req(1'b1, 1'b0, 1'b0, 16'h0201, 16'h0004, 1'b1, 1'b0, 16'h0000);
    st(16'h0089);
    fn(16'h0006);
    st(16'h008d);
    done("protect");
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    idle(2);
    cmp_flag(1'b0, irqCommon);
    st(16'h0089);
    done("clear");
    wrap_up();
  end
endmodule
